// [baseband_rx_buffer_flow_slot_timing_test.sv]
/* Testbench: bus and packet sequences with expected status and data.
   Assumes the partner model and a slot of 40 cycles. */
`timescale 1ns/1ps
`default_nettype none
module baseband_rx_buffer_flow_slot_timing_test;
    import brx_pkg::*;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, slotParityBit;
    logic [31:0] hrdata, rd;
    logic sendReq = 1'b0;
    logic [3:0] sendType = 4'h0;
    logic sendSeqn = 1'b0;
    logic [31:0] sendData = 32'h0;
    brx_link_in_s linkIn;
    brx_link_out_s linkOut;
    int fail_count = 0;
    int n_checks = 0;
    // Free-running system clock.
    always #4 clk = ~clk;
    brx_link_ctrl #(.SLOT_CYCLES(40)) brx_link_ctrl_i (.clk(clk), .sys_rst(sysRst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .linkIn(linkIn), .linkOut(linkOut), .txDataIn(32'h0),
        .txVoiceIn(32'h0), .keyStream(32'h0), .slotParityBit(slotParityBit));
    brx_remote_model brx_remote_model_i (.clk(clk), .sys_rst(sysRst),
        .slotParityBit(slotParityBit), .sendReq(sendReq), .sendType(sendType),
        .sendSeqn(sendSeqn), .sendData(sendData), .linkIn(linkIn));
    task automatic report_and_stop;
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // One single AHB-Lite word transfer; the bound stops a hung slave.
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] r);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 100);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 100);
        r = hrdata;
        if (n >= 100) begin
            fail_count++;
            report_and_stop();
        end
    endtask
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, 32'h04, 32'h0, rd);
        chk(e, rd & m);
    endtask
    task automatic send(input logic [3:0] t, input logic s, input logic [31:0] d);
        sendType <= t;
        sendSeqn <= s;
        sendData <= d;
        sendReq <= 1'b1;
        @(posedge clk);
        sendReq <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // Main sequence: fill, swap, duplicate, overrun with stop, release.
    initial begin
        repeat (20) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        xfer(1'b1, 32'h00, 32'h201, rd);
        xfer(1'b0, 32'h00, 32'h0, rd);
        chk(32'h201, rd & 32'hffff);
        xfer(1'b0, 32'h40, 32'h0, rd);
        chk(32'h0, rd);
        chk(32'h0, 32'(hresp));
        st(32'h4e, 32'h0);
        send(PT_DM1, 1'b0, 32'h5a5a1234);
        st(32'h24, 32'h24);
        xfer(1'b1, 32'h0c, 32'h0, rd);
        st(32'h46, 32'h42);
        xfer(1'b0, 32'h08, 32'h0, rd);
        chk(32'h5a5a1234, rd);
        send(PT_DM1, 1'b0, 32'h1111);
        st(32'h4, 32'h0);
        send(PT_DM1, 1'b1, 32'h2222);
        send(PT_DM1, 1'b0, 32'h3333);
        st(32'hc, 32'hc);
        send(PT_HV1, 1'b0, 32'h4444);
        st(32'hc, 32'hc);
        xfer(1'b1, 32'h0c, 32'h0, rd);
        st(32'hc, 32'h0);
        xfer(1'b0, 32'h08, 32'h0, rd);
        chk(32'h2222, rd);
        report_and_stop();
    end
endmodule
`default_nettype wire

// [brx_cfg.svh]
/*
 * Constants of the receive-buffer, flow-control and slot-timing block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef BRX_CFG_SVH
`define BRX_CFG_SVH

// Slot timing at the 125 MHz system clock.
`define BRX_CLK_MHZ 125
`define BRX_SLOT_US 625
`define BRX_JITTER_US 1
`define BRX_DRIFT_PPM 20
`define BRX_SLOT_CYCLES (`BRX_SLOT_US * `BRX_CLK_MHZ)
`define BRX_JITTER_CYCLES (`BRX_JITTER_US * `BRX_CLK_MHZ)
`define BRX_TRIG_PHASE 17'h00000

// Register byte offsets on the bus.
`define BRX_OFS_CTRL 8'h00
`define BRX_OFS_STATUS 8'h04
`define BRX_OFS_RXDATA 8'h08
`define BRX_OFS_RXDONE 8'h0c
`define BRX_OFS_TXCTRL 8'h10
`define BRX_OFS_VOICE 8'h14
`define BRX_OFS_OFFSET 8'h18

// Control register fields and reset values.
`define BRX_CTRL_MASTER 0
`define BRX_CTRL_SCO 1
`define BRX_CTRL_ENC 2
`define BRX_CTRL_POLL 3
`define BRX_CTRL_TYPE_LSB 4
`define BRX_CTRL_TSCO_LSB 8
`define BRX_TSCO_RST 8'h02
`define BRX_TXCTRL_TGT_LSB 8

// Header bit processing.
`define BRX_HEC_INIT 8'h00
`define BRX_HEC_POLY 8'ha7
`define BRX_HDR_BITS 10
`define BRX_CODED_BITS 18

`endif

// [brx_link_ctrl.sv]
/*
 * Link controller core: default packet selection, receive data and voice
 * double buffers, stop/go flow control both ways, header and payload bit
 * processing, and slot-parity transmit scheduling, with an AHB-Lite slave.
 * Assumes a single-bus-master AHB-Lite system with zero-wait answers and a
 * radio front end that delivers coded headers and one-word payloads.
 */
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

`include "brx_cfg.svh"

module brx_link_ctrl #(
    parameter int SLOT_CYCLES = `BRX_SLOT_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire brx_pkg::brx_link_in_s linkIn,
    output brx_pkg::brx_link_out_s linkOut,
    input wire logic [31:0] txDataIn,
    input wire logic [31:0] txVoiceIn,
    input wire logic [31:0] keyStream,
    output logic slotParityBit
);
    import brx_pkg::*;

    typedef struct packed {
        logic hreadyOut;
        logic [31:0] hrdata;
        logic wrPend;
        logic [7:0] wrAddr;
        logic isMaster;
        logic scoEnable;
        logic encEnable;
        logic pollReq;
        brx_ptype_e scoType;
        logic [7:0] voiceInterval;
        logic [7:0] txPending;
        logic [2:0] txTarget;
        logic [7:0] remoteStop;
        logic [1:0][31:0] dataBuf;
        logic dataSel;
        logic fillFull;
        logic readFull;
        logic stopPending;
        logic ackPending;
        logic lastSeqn;
        logic txSeqn;
        logic lastTxData;
        logic [1:0][31:0] voiceBuf;
        logic voiceSel;
        logic [7:0] voiceCnt;
        logic rxSeen;
        logic trigPrev;
        logic trigAny;
        logic txStart;
        brx_ptype_e txType;
        logic txSco;
        logic txFlow;
        logic [53:0] txHeader;
        logic [31:0] txPayload;
    } brx_state_s;

    brx_state_s r;
    brx_state_s n;
    brx_timer_s timer;

    logic [17:0] rxMajor;
    logic [17:0] rxPlain;
    logic [31:0] rxPayPlain;
    logic [17:0] txCoded;
    logic [31:0] txPayWhite;
    brx_hdr_s rxHdr;
    brx_hdr_s txHdr;
    logic [31:0] txPayRaw;
    logic [6:0] whiteSeed;
    logic rxHecOk;
    logic readDone;
    logic addrPhase;

    // Header error check over the ten header bits, shifted in LSB first.
    function automatic logic [7:0] hecCalc(input logic [9:0] h);
        logic [7:0] c;
        logic fb;
        c = `BRX_HEC_INIT;
        fb = 1'b0;
        for (int i = 0; i < `BRX_HDR_BITS; i++) begin
            fb = c[7] ^ h[i];
            c = {c[6:0], 1'b0} ^ ({8{fb}} & `BRX_HEC_POLY);
        end
        return c;
    endfunction

    function automatic logic carriesData(input brx_ptype_e t);
        return (t == PT_DM1) || (t == PT_DH1) || (t == PT_DV);
    endfunction

    function automatic logic carriesVoice(input brx_ptype_e t);
        return (t == PT_HV1) || (t == PT_HV2) || (t == PT_HV3) || (t == PT_DV);
    endfunction

    brx_slot_timer #(
        .SLOT_CYCLES(SLOT_CYCLES)
    ) u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .isMaster(r.isMaster),
        .resync(linkIn.accessTrig),
        .timer(timer)
    );

    // Both ends seed whitening from the slot clock, so they agree per slot.
    assign whiteSeed = {1'b1, timer.slotCount[5:0]};

    // Rate-1/3 repetition decode: a majority vote over the three copies.
    for (genvar i = 0; i < `BRX_CODED_BITS; i++) begin : g_major
        logic a;
        logic b;
        logic c;
        assign a = linkIn.rxHeader[i];
        assign b = linkIn.rxHeader[i + 18];
        assign c = linkIn.rxHeader[i + 36];
        assign rxMajor[i] = (a & b) | (a & c) | (b & c);
    end

    // Receive side undoes whitening before the check; transmit side after it.
    brx_whitener #(.WIDTH(18)) u_rxHdrWhite (
        .seed(whiteSeed),
        .dataIn(rxMajor),
        .dataOut(rxPlain)
    );
    brx_whitener #(.WIDTH(32)) u_rxPayWhite (
        .seed(whiteSeed),
        .dataIn(linkIn.rxPayload),
        .dataOut(rxPayPlain)
    );
    brx_whitener #(.WIDTH(18)) u_txHdrWhite (
        .seed(whiteSeed),
        .dataIn({hecCalc(txHdr), txHdr}),
        .dataOut(txCoded)
    );
    brx_whitener #(.WIDTH(32)) u_txPayWhite (
        .seed(whiteSeed),
        .dataIn(txPayRaw),
        .dataOut(txPayWhite)
    );

    assign rxHdr = rxPlain[9:0];
    assign rxHecOk = (hecCalc(rxPlain[9:0]) == rxPlain[17:10]);
    assign addrPhase = hsel && htrans[1] && hready;
    assign readDone = r.wrPend && (r.wrAddr == `BRX_OFS_RXDONE);

    // Transmit packet choice for the coming slot, highest priority first.
    always_comb begin
        logic ownSlot;
        logic scoSlot;
        logic dataOk;
        ownSlot = (timer.slotCount[0] == !r.isMaster);
        scoSlot = r.scoEnable && (r.voiceCnt == 8'h00);
        // A slave sends data only after a trigger in the slot just before.
        dataOk = r.txPending[r.txTarget] && !r.remoteStop[r.txTarget]
            && (r.isMaster || r.rxSeen);
        txHdr = '0;
        txHdr.addr = r.txTarget;
        txHdr.flow = !r.stopPending;
        txHdr.arqn = r.ackPending;
        txHdr.sequence_number_bit = r.txSeqn;
        txPayRaw = 32'h00000000;
        if (scoSlot && (r.isMaster || r.trigAny)) begin
            txHdr.ptype = r.scoType;
            txPayRaw = txVoiceIn;
        end else if (dataOk) begin
            txHdr.ptype = PT_DM1;
            txPayRaw = txDataIn;
        end else if (r.isMaster && r.pollReq) begin
            txHdr.ptype = PT_POLL;
        end else begin
            txHdr.ptype = PT_NULL;
        end
        // Encryption is optional per mode; whitening is never skipped.
        if (r.encEnable && (carriesData(txHdr.ptype) || carriesVoice(txHdr.ptype))) begin
            txPayRaw = txPayRaw ^ keyStream;
        end
        if (!timer.slotTick || !ownSlot) begin
            txHdr.ptype = PT_NULL;
        end
    end

    // Next state: bus slave, buffers, flow control and transmit scheduling.
    always_comb begin
        logic ownSlot;
        logic sendNow;
        logic [2:0] src;
        logic [31:0] rxPay;
        ownSlot = (timer.slotCount[0] == !r.isMaster);
        src = r.isMaster ? rxHdr.addr : 3'h0;
        rxPay = r.encEnable ? (rxPayPlain ^ keyStream) : rxPayPlain;
        n = r;
        n.txStart = 1'b0;
        n.hreadyOut = 1'b1;

        // Register writes land in the data phase after the address phase.
        if (r.wrPend) begin
            unique case (r.wrAddr)
                `BRX_OFS_CTRL: begin
                    n.isMaster = hwdata[`BRX_CTRL_MASTER];
                    n.scoEnable = hwdata[`BRX_CTRL_SCO];
                    n.encEnable = hwdata[`BRX_CTRL_ENC];
                    n.pollReq = hwdata[`BRX_CTRL_POLL];
                    n.scoType = brx_ptype_e'(hwdata[`BRX_CTRL_TYPE_LSB +: 4]);
                    n.voiceInterval = hwdata[`BRX_CTRL_TSCO_LSB +: 8];
                end
                `BRX_OFS_TXCTRL: begin
                    n.txPending = r.txPending | hwdata[7:0];
                    n.txTarget = hwdata[`BRX_TXCTRL_TGT_LSB +: 3];
                end
                default: begin
                end
            endcase
        end
        n.wrPend = addrPhase && hwrite;
        n.wrAddr = haddr[7:0];

        // Read data is captured in the address phase and stands in the data phase.
        if (addrPhase && !hwrite) begin
            n.hrdata = 32'h00000000;
            if (haddr[31:8] == 24'h000000) begin
                unique case (haddr[7:0])
                    `BRX_OFS_CTRL: n.hrdata = {16'h0000, r.voiceInterval, 4'(r.scoType),
                        r.pollReq, r.encEnable, r.scoEnable, r.isMaster};
                    `BRX_OFS_STATUS: n.hrdata = {r.remoteStop, r.txPending, 8'h00,
                        r.voiceSel, r.dataSel, r.ackPending, r.trigAny,
                        r.stopPending, r.fillFull, r.readFull, timer.slotCount[0]};
                    `BRX_OFS_RXDATA: n.hrdata = r.dataBuf[!r.dataSel];
                    `BRX_OFS_VOICE: n.hrdata = r.voiceBuf[!r.voiceSel];
                    `BRX_OFS_OFFSET: n.hrdata = {15'h0000, timer.clkOffset};
                    default: n.hrdata = 32'h00000000;
                endcase
            end
        end

        // Manager finished the old register: the filled one becomes readable.
        if (readDone) begin
            n.dataSel = !r.dataSel;
            n.readFull = r.fillFull;
            n.fillFull = 1'b0;
            n.stopPending = 1'b0;
        end

        // Access triggers feed slave receive timing, whatever the packet holds.
        if (linkIn.accessTrig) begin
            n.rxSeen = 1'b1;
            n.trigAny = 1'b1;
        end

        // Header-checked packets only; a bad header drops the packet.
        if (linkIn.rxValid && rxHecOk) begin
            n.remoteStop[src] = !rxHdr.flow;
            if (rxHdr.arqn && r.lastTxData) begin
                n.txPending[src] = 1'b0;
                n.txSeqn = !r.txSeqn;
                n.lastTxData = 1'b0;
            end
            // Voice goes through regardless of the data flow state.
            if (carriesVoice(rxHdr.ptype)) begin
                n.voiceBuf[r.voiceSel] = rxPay;
            end
            if (carriesData(rxHdr.ptype)) begin
                if (rxHdr.sequence_number_bit == r.lastSeqn) begin
                    n.ackPending = 1'b1;
                end else if (!r.fillFull && !(readDone && r.readFull)) begin
                    n.dataBuf[r.dataSel ^ readDone] = rxPay;
                    n.fillFull = 1'b1;
                    n.lastSeqn = rxHdr.sequence_number_bit;
                    n.ackPending = 1'b1;
                    if (r.readFull && !readDone) begin
                        n.stopPending = 1'b1;
                    end
                end else begin
                    // No room: refuse without acknowledging, so it comes again.
                    n.stopPending = 1'b1;
                end
            end
        end

        // Slot boundary bookkeeping.
        if (timer.slotTick) begin
            n.rxSeen = 1'b0;
            if (ownSlot) begin
                n.trigPrev = r.rxSeen;
                // Nothing heard from any party in the slot counts as go for the addressed one.
                if (!r.rxSeen) begin
                    n.remoteStop[r.isMaster ? r.txTarget : 3'h0] = 1'b0;
                end
            end
            if (!timer.slotCount[0]) begin
                if (r.voiceCnt >= r.voiceInterval - 8'h01) begin
                    n.voiceCnt = 8'h00;
                    n.voiceSel = !r.voiceSel;
                end else begin
                    n.voiceCnt = r.voiceCnt + 8'h01;
                end
            end
        end

        // Launch: nothing at all on an idle link with nothing to report.
        sendNow = timer.slotTick && ownSlot && ((txHdr.ptype != PT_NULL)
            || r.ackPending || r.stopPending);
        if (sendNow) begin
            n.txStart = 1'b1;
            n.txType = txHdr.ptype;
            n.txSco = carriesVoice(txHdr.ptype);
            n.txFlow = txHdr.flow;
            n.txHeader = {txCoded, txCoded, txCoded};
            n.txPayload = txPayWhite;
            n.ackPending = 1'b0;
            n.lastTxData = carriesData(txHdr.ptype);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r <= '0;
            r.voiceInterval <= `BRX_TSCO_RST;
            r.lastSeqn <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign hreadyout = r.hreadyOut;
    assign hresp = 1'b0;
    assign hrdata = r.hrdata;
    assign linkOut.txStart = r.txStart;
    assign linkOut.txHeader = r.txHeader;
    assign linkOut.txPayload = r.txPayload;
    assign slotParityBit = timer.slotCount[0];

    // A null leaves only when there is acknowledge or stop to carry.
    AST_NULL_ONLY_PENDING: assert property (@(posedge clk) disable iff (sys_rst)
        r.txStart && r.txType == PT_NULL |-> $past(r.ackPending || r.stopPending))
        else $error("null packet sent with nothing to report");

    // Voice slots carry the agreed voice type.
    AST_SCO_TYPE: assert property (@(posedge clk) disable iff (sys_rst)
        r.txStart && r.txSco |-> r.txType == r.scoType)
        else $error("voice slot sent a foreign type");

    // Transmit starts only in the role's own slot parity.
    AST_SLOT_PARITY: assert property (@(posedge clk) disable iff (sys_rst)
        r.txStart |-> timer.slotCount[0] == !r.isMaster)
        else $error("transmission started in the wrong slot parity");

    // The flow bit sent mirrors the stop state at launch.
    AST_FLOW_BIT: assert property (@(posedge clk) disable iff (sys_rst)
        r.txStart |-> r.txFlow == !$past(r.stopPending))
        else $error("flow bit disagrees with stop state");

    // Stop stays until the manager finishes a read.
    AST_STOP_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        r.stopPending && !readDone |=> r.stopPending)
        else $error("stop indication dropped without a read");

    // Read complete with no packet in the same cycle swaps the data selector and clears stop.
    AST_DATA_SWAP: assert property (@(posedge clk) disable iff (sys_rst)
        readDone && !(linkIn.rxValid && rxHecOk) |=> r.dataSel != $past(r.dataSel)
        && !r.stopPending)
        else $error("read complete did not swap the data registers");

    // The voice selector swaps once per voice interval.
    AST_VOICE_SWAP: assert property (@(posedge clk) disable iff (sys_rst)
        timer.slotTick && !timer.slotCount[0] && r.voiceCnt >= r.voiceInterval - 8'h01
        |=> r.voiceSel != $past(r.voiceSel))
        else $error("voice selector missed its interval");

    // A duplicate sequence bit never changes the stored data.
    AST_NO_DUPLICATE: assert property (@(posedge clk) disable iff (sys_rst)
        linkIn.rxValid && rxHecOk && carriesData(rxHdr.ptype) && rxHdr.sequence_number_bit == r.lastSeqn
        |=> $stable(r.dataBuf))
        else $error("duplicate payload was stored");

    // Outside voice slots, data never goes to a party that is signalling stop.
    AST_STOP_STALLS: assert property (@(posedge clk) disable iff (sys_rst)
        r.txStart && r.lastTxData && !r.txSco |-> !$past(r.remoteStop[r.txTarget]))
        else $error("data sent to a stopped party");
endmodule

`default_nettype wire

// [brx_pkg.sv]
/*
 * Types shared by the receive-buffer and slot-timing block.
 * Assumes brx_cfg.svh is on the include path.
 */
`include "brx_cfg.svh"

package brx_pkg;

    // Packet types carried in the header type field.
    typedef enum logic [3:0] {
        PT_NULL, PT_POLL, PT_FHS, PT_DM1, PT_DH1, PT_HV1, PT_HV2, PT_HV3, PT_DV
    } brx_ptype_e;

    // Plain packet header before error check, whitening and coding.
    typedef struct packed {
        logic [2:0] addr;
        brx_ptype_e ptype;
        logic flow;
        logic arqn;
        logic sequence_number_bit;
    } brx_hdr_s;

    // Radio side towards the block.
    typedef struct packed {
        logic rxValid;
        logic [53:0] rxHeader;
        logic [31:0] rxPayload;
        logic accessTrig;
    } brx_link_in_s;

    // Block towards the radio side.
    typedef struct packed {
        logic txStart;
        logic [53:0] txHeader;
        logic [31:0] txPayload;
    } brx_link_out_s;

    // State of the slot timer.
    typedef struct packed {
        logic [16:0] phase;
        logic [15:0] slotCount;
        logic slotTick;
        logic [16:0] clkOffset;
    } brx_timer_s;

endpackage

// [brx_remote_model.sv]
/* Remote unit: codes one packet and presents it to the block on request.
   Assumes the block's slot counter starts at 0 and steps once per parity change. */
`timescale 1ns/1ps
`default_nettype none
module brx_remote_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic slotParityBit,
    input wire logic sendReq,
    input wire logic [3:0] sendType,
    input wire logic sendSeqn,
    input wire logic [31:0] sendData,
    output brx_pkg::brx_link_in_s linkIn
);
    import brx_pkg::*;
    logic lastPar;
    logic [5:0] slotCnt;
    logic [49:0] coded;
    // Check byte over the header, then a whitening run over the header and a fresh run over the payload.
    function automatic logic [49:0] code(input logic [9:0] h, input logic [31:0] p,
            input logic [5:0] s);
        logic [7:0] c;
        logic [6:0] w;
        logic [49:0] v;
        c = 8'h00;
        for (int i = 0; i < 10; i++)
            c = (c << 1) ^ ((c[7] ^ h[i]) ? 8'ha7 : 8'h00);
        v = {p, c, h};
        w = {1'b1, s};
        // The block restarts the whitening run for the payload word.
        for (int i = 0; i < 50; i++) begin
            if (i == 18)
                w = {1'b1, s};
            v[i] = v[i] ^ w[6];
            w = {w[5:0], w[6] ^ w[3]};
        end
        return v;
    endfunction
    // The seed must match the slot in which the block samples, hence the live parity term.
    assign coded = code({3'h1, sendType, 1'b1, 1'b0, sendSeqn}, sendData,
        slotCnt + 6'(slotParityBit ^ lastPar));
    // Outside a frame the lines carry the inverse pattern, never a stale copy.
    assign linkIn = {sendReq, {3{coded[17:0]}} ^ {54{~sendReq}},
        coded[49:18] ^ {32{~sendReq}}, sendReq};
    // Slot tracking from the block's own parity output.
    always_ff @(posedge clk) begin
        lastPar <= slotParityBit;
        if (sys_rst) begin
            slotCnt <= 6'h00;
        end else begin
            slotCnt <= slotCnt + 6'(slotParityBit ^ lastPar);
        end
    end
endmodule
`default_nettype wire

// [brx_slot_timer.sv]
/*
 * Native slot clock: counts system cycles into slots and slots into the
 * slot counter whose bit 0 is the slot parity bit. A slave realigns on
 * access-code triggers; a master never adjusts its timing.
 * Assumes triggers arrive as one-cycle pulses in the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

`include "brx_cfg.svh"

module brx_slot_timer #(
    parameter int SLOT_CYCLES = `BRX_SLOT_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic isMaster,
    input wire logic resync,
    output brx_pkg::brx_timer_s timer
);
    import brx_pkg::*;

    brx_timer_s r;
    brx_timer_s n;

    // Each slot is an exact whole number of cycles, so the average slot
    // carries no drift beyond the crystal and no jitter at all.
    always_comb begin
        n = r;
        n.slotTick = 1'b0;
        if (r.phase == 17'(SLOT_CYCLES - 1)) begin
            n.phase = 17'h00000;
            n.slotCount = r.slotCount + 16'h0001;
            n.slotTick = 1'b1;
        end else begin
            n.phase = r.phase + 17'h00001;
        end
        // Only a slave follows the remote clock; the master keeps its own.
        if (resync && !isMaster) begin
            n.clkOffset = r.phase - `BRX_TRIG_PHASE;
            n.phase = `BRX_TRIG_PHASE + 17'h00001;
            n.slotCount = {r.slotCount[15:1], 1'b0};
            n.slotTick = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign timer = r;
endmodule

`default_nettype wire

// [brx_whitener.sv]
/*
 * Whitening scrambler: XORs a word with the sequence of a seven-bit
 * shift register (x^7 + x^4 + 1). The same module whitens and de-whitens.
 * Assumes the caller supplies the seed taken from the slot clock.
 */
`timescale 1ns/1ps
`default_nettype none

module brx_whitener #(
    parameter int WIDTH = 18
) (
    input wire logic [6:0] seed,
    input wire logic [WIDTH-1:0] dataIn,
    output logic [WIDTH-1:0] dataOut
);
    // The register is stepped once per bit so the whole word is done in one cycle.
    always_comb begin
        logic [6:0] lfsr;
        logic fb;
        lfsr = seed;
        fb = 1'b0;
        for (int i = 0; i < WIDTH; i++) begin
            dataOut[i] = dataIn[i] ^ lfsr[6];
            fb = lfsr[6] ^ lfsr[3];
            lfsr = {lfsr[5:0], fb};
        end
    end
endmodule

`default_nettype wire
